// ==== ebc_cycle.sv ====
// Purpose: External bus cycle engine with window control and reset config
// Assumes: Avalon-MM register slave, synchronous active high reset
// Notes: Windows 0 and 4 only; first reset after power up must be long
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module ebc_cycle #(
    parameter int RDY_SYNC = 3
) (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic long_reset,
    // Register bus
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Core access port
    input wire ebc_pkg::ebc_req_t core_req,
    output ebc_pkg::ebc_rsp_t core_rsp,
    // Pins
    input wire logic external_access_pin,
    input wire logic [15:0] port0_cfg,
    input wire logic ready_in,
    input wire logic [15:0] data_in,
    output ebc_pkg::ebc_pins_t pins
);
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ALE = 6'h02,
        ST_DELAY = 6'h04,
        ST_STROBE = 6'h08,
        ST_READY = 6'h10,
        ST_TURN = 6'h20
    } ebc_state_t;

    // Three flop filter on pins
    localparam int SW = 34;
    logic [SW-1:0] s1_reg, s2_reg, s3_reg, stable_reg, stable_next;
    always_comb begin
        stable_next = stable_reg;
        for (int i = 0; i < SW; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                stable_next[i] = s3_reg[i];
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (ce) begin
            s1_reg <= {external_access_pin, ready_in, port0_cfg, data_in};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            stable_reg <= stable_next;
        end
    end
    logic ea_s, rdy_s;
    logic [15:0] cfg_s;
    logic [15:0] din_s;
    // Filtered value is usable as soon as the second and third flops agree
    assign {ea_s, rdy_s, cfg_s, din_s} = stable_next;

    function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r & ebc_pkg::CTRL_WMASK;
    endfunction

    // Register file
    logic [15:0] win0_reg, win0_next, win4_reg, win4_next, range_reg, range_next;
    logic [7:0] rcfg_reg, rcfg_next;
    logic ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    logic acc;
    assign acc = (avs_read | avs_write) & ~ack_reg;
    always_comb begin
        win0_next = win0_reg;
        win4_next = win4_reg;
        range_next = range_reg;
        rcfg_next = rcfg_reg;
        ack_next = acc;
        rdata_next = rdata_reg;
        if (rst) begin
            rcfg_next[4:0] = cfg_s[12:8];
            if (long_reset) begin
                rcfg_next[7:5] = cfg_s[15:13];
            end
            win4_next = ebc_pkg::CTRL_RESET;
            range_next = ebc_pkg::CTRL_RESET;
            ack_next = 1'b0;
            if (ea_s) begin
                win0_next = ebc_pkg::CTRL_RESET;
            end else begin
                win0_next = ebc_pkg::CTRL_RESET;
                win0_next[ebc_pkg::WAB_POS] = 1'b1;
                win0_next[ebc_pkg::LSB_POS] = 1'b1;
                win0_next[ebc_pkg::BFF_LSB +: 2] = cfg_s[7:6];
            end
        end else if (acc) begin
            rdata_next = 32'h0;
            case (avs_address)
                ebc_pkg::WIN0_CTRL_ADDR: begin
                    rdata_next[15:0] = win0_reg;
                    if (avs_write) begin
                        win0_next = wmerge(win0_reg, avs_writedata, avs_byteenable);
                    end
                end
                ebc_pkg::WIN4_CTRL_ADDR: begin
                    rdata_next[15:0] = win4_reg;
                    if (avs_write) begin
                        win4_next = wmerge(win4_reg, avs_writedata, avs_byteenable);
                    end
                end
                ebc_pkg::WIN4_RANGE_ADDR: begin
                    rdata_next[15:0] = range_reg;
                    if (avs_write) begin
                        range_next = wmerge(range_reg, avs_writedata, avs_byteenable)
                            | ~ebc_pkg::CTRL_WMASK & range_reg;
                        if (avs_byteenable[1]) begin
                            range_next[11:8] = avs_writedata[11:8];
                        end
                    end
                end
                ebc_pkg::RST_CFG_ADDR: begin
                    rdata_next[7:0] = rcfg_reg;
                end
                ebc_pkg::SYS_CTRL_ADDR: begin
                    rdata_next[0] = ~rcfg_reg[ebc_pkg::WSM_POS];
                end
                default: begin
                    rdata_next = 32'h0;
                end
            endcase
        end
    end
    always_ff @(posedge ref_clk) begin
        if (ce) begin
            win0_reg <= win0_next;
            win4_reg <= win4_next;
            range_reg <= range_next;
            rcfg_reg <= rcfg_next;
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
        end
    end
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign avs_readdata = rdata_reg;

    // Window decode; range: [15:4] base of addr[23:12], [3:0] size exponent
    logic hit4;
    logic [11:0] rmask;
    assign rmask = 12'hfff << range_reg[3:0];
    assign hit4 = win4_reg[ebc_pkg::WAB_POS]
        && ((core_req.addr[23:12] & rmask) == (range_reg[15:4] & rmask));

    // Cycle engine
    ebc_state_t st_reg, st_next;
    logic [15:0] cur_reg, cur_next;
    logic win4_sel_reg, win4_sel_next;
    logic is_rd_reg, is_rd_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [23:0] addr_reg, addr_next;
    logic [15:0] wd_reg, wd_next;
    logic [1:0] be_reg, be_next;
    ebc_pkg::ebc_rsp_t rsp_reg, rsp_next;
    logic busy;
    assign busy = st_reg != ST_IDLE;

    always_comb begin
        st_next = st_reg;
        cur_next = cur_reg;
        win4_sel_next = win4_sel_reg;
        is_rd_next = is_rd_reg;
        cnt_next = cnt_reg;
        addr_next = addr_reg;
        wd_next = wd_reg;
        be_next = be_reg;
        rsp_next = rsp_reg;
        rsp_next.done = 1'b0;
        rsp_next.err = 1'b0;
        case (st_reg)
            ST_IDLE: begin
                // Request still standing while done is shown is the old one
                if ((core_req.rd | core_req.wr) && !rsp_reg.done) begin
                    addr_next = core_req.addr;
                    wd_next = core_req.wdata;
                    be_next = core_req.be;
                    is_rd_next = core_req.rd;
                    win4_sel_next = hit4;
                    cur_next = hit4 ? win4_reg : win0_reg;
                    if (!hit4 && !win0_reg[ebc_pkg::WAB_POS]) begin
                        rsp_next.done = 1'b1;
                        rsp_next.err = 1'b1;
                    end else begin
                        st_next = ST_ALE;
                        cnt_next = win0_reg[ebc_pkg::LSB_POS] && !hit4
                            || hit4 && win4_reg[ebc_pkg::LSB_POS]
                            ? 4'(ebc_pkg::ALE_LONG_CYC) : 4'(ebc_pkg::ALE_NORM_CYC);
                    end
                end
            end
            ST_ALE: begin
                cnt_next = cnt_reg - 4'h1;
                if (cnt_reg == 4'h1) begin
                    if (!cur_reg[ebc_pkg::SDB_POS]) begin
                        st_next = ST_DELAY;
                    end else begin
                        st_next = ST_STROBE;
                    end
                    cnt_next = ebc_pkg::MAX_WAITS - cur_reg[ebc_pkg::CWF_LSB +: 4];
                end
            end
            ST_DELAY: begin
                st_next = ST_STROBE;
            end
            ST_STROBE: begin
                if (cnt_reg != 4'h0) begin
                    cnt_next = cnt_reg - 4'h1;
                end else if (cur_reg[ebc_pkg::RUB_POS]) begin
                    st_next = ST_READY;
                end else begin
                    rsp_next.done = 1'b1;
                    rsp_next.rdata = din_s;
                    st_next = cur_reg[ebc_pkg::TWB_POS] ? ST_IDLE : ST_TURN;
                end
            end
            ST_READY: begin
                if (rdy_s == cur_reg[ebc_pkg::RLB_POS]) begin
                    rsp_next.done = 1'b1;
                    rsp_next.rdata = din_s;
                    st_next = cur_reg[ebc_pkg::TWB_POS] ? ST_IDLE : ST_TURN;
                end
            end
            ST_TURN: begin
                st_next = ST_IDLE;
            end
            default: begin
                st_next = ST_IDLE;
            end
        endcase
        if (rst) begin
            st_next = ST_IDLE;
            cnt_next = 4'h0;
            cur_next = ebc_pkg::CTRL_RESET;
            win4_sel_next = 1'b0;
            is_rd_next = 1'b0;
            addr_next = 24'h0;
            wd_next = 16'h0;
            be_next = 2'h0;
            rsp_next = '0;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (ce) begin
            st_reg <= st_next;
            cur_reg <= cur_next;
            win4_sel_reg <= win4_sel_next;
            is_rd_reg <= is_rd_next;
            cnt_reg <= cnt_next;
            addr_reg <= addr_next;
            wd_reg <= wd_next;
            be_reg <= be_next;
            rsp_reg <= rsp_next;
        end
    end
    assign core_rsp = rsp_reg;

    // Pin outputs
    logic strobe, mux, wide;
    logic [4:0] cs_en;
    logic [7:0] seg_en;
    assign strobe = st_reg == ST_STROBE || st_reg == ST_READY;
    assign mux = cur_reg[ebc_pkg::BFF_LSB];
    assign wide = cur_reg[ebc_pkg::BFF_LSB + 1];
    always_comb begin
        case (rcfg_reg[ebc_pkg::SCF_LSB +: 2])
            2'b00: cs_en = 5'h07;
            2'b01: cs_en = 5'h03;
            2'b10: cs_en = 5'h00;
            default: cs_en = 5'h1f;
        endcase
        case (rcfg_reg[ebc_pkg::SLF_LSB +: 2])
            2'b00: seg_en = 8'h0f;
            2'b01: seg_en = 8'h00;
            2'b10: seg_en = 8'hff;
            default: seg_en = 8'h03;
        endcase
    end
    logic cs_act, wr_act, hi_byte;
    assign wr_act = strobe & ~is_rd_reg;
    assign hi_byte = wide & be_reg[1];
    always_comb begin
        cs_act = busy && st_reg != ST_TURN;
        if (is_rd_reg && cur_reg[ebc_pkg::SRB_POS]) begin
            cs_act = strobe;
        end
        if (!is_rd_reg && cur_reg[ebc_pkg::SWB_POS]) begin
            cs_act = strobe;
        end
        pins = '0;
        pins.ale = st_reg == ST_ALE;
        pins.rd_n = ~(strobe & is_rd_reg);
        if (!rcfg_reg[ebc_pkg::WSM_POS]) begin
            pins.wr_n = ~(wr_act & be_reg[0]);
            pins.bhe_n = ~(wr_act & hi_byte);
        end else begin
            pins.wr_n = ~wr_act;
            pins.bhe_n = ~(busy & hi_byte);
        end
        pins.cs_n = 5'h1f;
        if (cs_act) begin
            pins.cs_n[win4_sel_reg ? 4 : 0] = ~cs_en[win4_sel_reg ? 4 : 0];
        end
        pins.seg_oe = seg_en;
        pins.addr = {addr_reg[23:16] & seg_en, addr_reg[15:0]};
        if (mux && st_reg == ST_ALE) begin
            pins.data_out = addr_reg[15:0];
            pins.data_oe = 1'b1;
        end else if (wr_act || st_reg == ST_DELAY && !is_rd_reg) begin
            pins.data_out = wide ? wd_reg : {8'h00, wd_reg[7:0]};
            pins.data_oe = 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== ebc_cycle_sva.sv ====
// Purpose: Pin timing checks for the external bus cycle engine
// Assumes: Window 4 stays inactive; window 0 control is shadowed from bus writes
// Notes: Pin checks start after the first window 0 control write
`timescale 1ns/100ps
`default_nettype none
module ebc_chk (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register bus
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    // Core side and pins
    input wire ebc_pkg::ebc_rsp_t core_rsp,
    input wire ebc_pkg::ebc_pins_t pins
);
    logic [15:0] s0_reg, s0_next;
    logic sv_reg, sv_next;
    logic [4:0] cnt_reg, cnt_next;
    logic stb;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    assign stb = !(pins.rd_n && pins.wr_n);
    // Shadow of window 0 control and strobe length
    always_comb begin
        s0_next = s0_reg;
        sv_next = sv_reg && !rst;
        cnt_next = stb ? cnt_reg + 5'h01 : 5'h00;
        if (avs_write && !avs_waitrequest && avs_address == ebc_pkg::WIN0_CTRL_ADDR) begin
            s0_next = avs_writedata[15:0];
            sv_next = !rst;
        end
    end
    always_ff @(posedge ref_clk) begin
        s0_reg <= s0_next;
        sv_reg <= sv_next;
        cnt_reg <= cnt_next;
    end
    sequence stb_on_s;
        !(pins.rd_n && pins.wr_n);
    endsequence
    sequence stb_end_s;
        !stb && $past(stb);
    endsequence
    bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("register access not answered in one cycle");
    wait_count_a: assert property (sv_reg && !s0_reg[12] ##0 stb_end_s |->
        cnt_reg == 5'd16 - {1'b0, s0_reg[3:0]}) else $error("strobe length wrong");
    ready_wait_a: assert property (sv_reg && s0_reg[12] ##0 stb_end_s |->
        cnt_reg >= 5'd16 - {1'b0, s0_reg[3:0]}) else $error("ready ended cycle early");
    strobe_early_a: assert property (sv_reg && s0_reg[4] && $fell(pins.ale) |-> stb_on_s)
        else $error("strobe late without delay");
    strobe_late_a: assert property (sv_reg && !s0_reg[4] && $fell(pins.ale) |->
        !stb ##1 stb_on_s) else $error("strobe delay wrong");
    latch_short_a: assert property (sv_reg && !s0_reg[9] && $rose(pins.ale) |=> !pins.ale)
        else $error("latch pulse too long");
    latch_long_a: assert property (sv_reg && s0_reg[9] && $rose(pins.ale) |=>
        pins.ale ##1 !pins.ale) else $error("latch pulse not stretched");
    select_gate_a: assert property (sv_reg && s0_reg[15:14] == 2'b11 && !pins.cs_n[0] |->
        stb_on_s) else $error("select outside strobe");
    window_off_a: assert property (sv_reg && !s0_reg[10] |-> !pins.ale && pins.cs_n[0])
        else $error("cycle on disabled window");
    window_err_a: assert property (sv_reg && !s0_reg[10] && core_rsp.done |-> core_rsp.err)
        else $error("no error on disabled window");
    mux_addr_a: assert property (sv_reg && s0_reg[6] && pins.ale |->
        pins.data_oe && pins.data_out == pins.addr[15:0]) else $error("address not on data lines");
endmodule
bind ebc_cycle ebc_chk u_chk (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_waitrequest(avs_waitrequest), .core_rsp(core_rsp), .pins(pins));
`default_nettype wire

// ==== ebc_mem.sv ====
// Purpose: External memory with programmable ready on the parallel bus
// Assumes: 16-bit demultiplexed bus, chip select 0
// Notes: Released data lines toggle every cycle
`timescale 1ns/100ps
`default_nettype none
module ebc_mem #(
    parameter int RDY_DLY = 6
) (
    // Clock
    input wire logic ref_clk,
    // Bus side
    input wire ebc_pkg::ebc_pins_t pins,
    input wire logic ready_lvl,
    output logic [15:0] data_in,
    output logic ready_in
);
    logic [15:0] mem [256];
    logic [15:0] last_reg = 16'h0000;
    logic [7:0] cnt_reg = 8'h00;
    logic drv;
    assign drv = !pins.rd_n || !pins.cs_n[0];
    assign data_in = drv ? mem[pins.addr[8:1]] : ~last_reg;
    // Terminating level only after the programmed delay
    assign ready_in = (cnt_reg >= 8'(RDY_DLY)) ? ready_lvl : !ready_lvl;
    always_ff @(posedge ref_clk) begin
        last_reg <= data_in;
        cnt_reg <= (pins.rd_n && pins.wr_n) ? 8'h00 : cnt_reg + 8'h01;
        if (!pins.wr_n) begin
            mem[pins.addr[8:1]] <= pins.data_out;
        end
    end
endmodule
`default_nettype wire

// ==== ebc_pkg.sv ====
// Purpose: Constants, types and register map of the external bus cycle block
// Assumes: 100 MHz ref_clk, one ref_clk cycle stands for one half_clock_period
package ebc_pkg;
    // Register byte addresses
    localparam logic [15:0] WIN0_CTRL_ADDR = 16'hf100;
    localparam logic [15:0] WIN4_CTRL_ADDR = 16'hf104;
    localparam logic [15:0] RST_CFG_ADDR = 16'hf108;
    localparam logic [15:0] WIN4_RANGE_ADDR = 16'hf10c;
    localparam logic [15:0] SYS_CTRL_ADDR = 16'hf110;
    // Control field positions
    localparam int CWF_LSB = 0;
    localparam int SDB_POS = 4;
    localparam int TWB_POS = 5;
    localparam int BFF_LSB = 6;
    localparam int LSB_POS = 9;
    localparam int WAB_POS = 10;
    localparam int RUB_POS = 12;
    localparam int RLB_POS = 13;
    localparam int SRB_POS = 14;
    localparam int SWB_POS = 15;
    localparam logic [15:0] CTRL_WMASK = 16'hf6ff;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    // Reset configuration field positions
    localparam int WSM_POS = 0;
    localparam int SCF_LSB = 1;
    localparam int SLF_LSB = 3;
    localparam int CRF_LSB = 5;
    localparam logic [3:0] MAX_WAITS = 4'hf;
    // Timing in half_clock_period units, one ref_clk each
    localparam int TCL_NS = 10;
    localparam int CLK_NS = 10;
    localparam int TCL_CYC = (TCL_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0] ALE_NORM_CYC = 2'(TCL_CYC);
    localparam logic [1:0] ALE_LONG_CYC = 2'(2 * TCL_CYC);

    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] wdata;
        logic [1:0] be;
        logic rd;
        logic wr;
    } ebc_req_t;

    typedef struct packed {
        logic done;
        logic err;
        logic [15:0] rdata;
    } ebc_rsp_t;

    typedef struct packed {
        logic ale;
        logic rd_n;
        logic wr_n;
        logic bhe_n;
        logic [4:0] cs_n;
        logic [23:0] addr;
        logic [7:0] seg_oe;
        logic [15:0] data_out;
        logic data_oe;
    } ebc_pins_t;
endpackage

// ==== external_bus_cycle_config_bench.sv ====
// Purpose: Self-checking bench for the external bus cycle block
// Assumes: Window 4 left inactive, all traffic in window 0
// Notes: Scoreboard queues filled by drivers, emptied by the monitor
`timescale 1ns/100ps
`default_nettype none
module external_bus_cycle_config_bench;
    localparam logic [7:0] SEG[4] = '{8'h0f, 8'h00, 8'hff, 8'h03};
    localparam logic [3:0] WS[3] = '{4'h0, 4'h9, 4'hf};
    logic ref_clk, rst, long_reset, ea, ready_in, ready_lvl, avs_read, avs_write, avs_waitrequest;
    logic [15:0] avs_address, port0_cfg, data_in, c, w, d;
    logic [31:0] avs_writedata, avs_readdata, rs;
    logic [23:0] a;
    logic [17:0] note;
    ebc_pkg::ebc_req_t core_req;
    ebc_pkg::ebc_rsp_t core_rsp;
    ebc_pkg::ebc_pins_t pins;
    logic [31:0] reg_q[$];
    logic [17:0] core_q[$];
    logic cs_low, wr_low, bhe_low;
    int stb_cnt, err_total, total_checks;
    ebc_cycle u_dut (.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .long_reset(long_reset),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .core_req(core_req), .core_rsp(core_rsp),
        .external_access_pin(ea), .port0_cfg(port0_cfg), .ready_in(ready_in),
        .data_in(data_in), .pins(pins));
    ebc_mem u_mem (.ref_clk(ref_clk), .pins(pins), .ready_lvl(ready_lvl), .data_in(data_in),
        .ready_in(ready_in));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic hang();
        err_total++;
        $display("CHECK FAILED t=%0t no answer", $time);
        final_report();
    endtask
    // Register access, read expectations noted for the monitor
    task automatic bus(input logic we, input logic [15:0] ad, input logic [15:0] wd,
        input logic [15:0] exp);
        int n;
        @(posedge ref_clk);
        avs_address <= ad;
        avs_write <= we;
        avs_read <= !we;
        avs_writedata <= {16'h0, wd};
        if (!we) reg_q.push_back({16'h0, exp});
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest && n < 50);
        if (avs_waitrequest) hang();
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // Core transfer; note holds data-check flag, error and read data
    task automatic core(input logic r, input logic [23:0] ad, input logic [15:0] wd,
        input logic [1:0] be, input logic [17:0] exp);
        int n;
        @(posedge ref_clk);
        cs_low = 1'b0;
        wr_low = 1'b0;
        bhe_low = 1'b0;
        stb_cnt = 0;
        core_req <= '{addr: ad, wdata: wd, be: be, rd: r, wr: !r};
        core_q.push_back(exp);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (!core_rsp.done && n < 200);
        if (!core_rsp.done) hang();
        core_req.rd <= 1'b0;
        core_req.wr <= 1'b0;
    endtask
    task automatic reset_dut(input logic lr, input logic e, input logic [15:0] cfg);
        @(posedge ref_clk);
        rst <= 1'b1;
        long_reset <= lr;
        ea <= e;
        port0_cfg <= cfg;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        long_reset <= 1'b0;
    endtask
    always @(posedge ref_clk) begin
        if (avs_read && !avs_waitrequest) check(avs_readdata, reg_q.pop_front());
        if (core_rsp.done) begin
            note = core_q.pop_front();
            check({31'h0, core_rsp.err}, {31'h0, note[16]});
            if (note[17]) check({16'h0, core_rsp.rdata}, {16'h0, note[15:0]});
        end
        if (!pins.cs_n[0]) cs_low <= 1'b1;
        if (!pins.wr_n) wr_low <= 1'b1;
        if (!pins.bhe_n) bhe_low <= 1'b1;
        if (!(pins.rd_n && pins.wr_n)) stb_cnt <= stb_cnt + 1;
    end
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        {rst, long_reset, ea} = 3'b111;
        {ready_lvl, avs_read, avs_write} = 3'b000;
        port0_cfg = 16'hffff;
        avs_address = 16'h0;
        avs_writedata = 32'h0;
        core_req = '0;
        err_total = 0;
        total_checks = 0;
        rs = $urandom(47232);
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        long_reset <= 1'b0;
        bus(0, ebc_pkg::RST_CFG_ADDR, 16'h0, 16'h00ff);
        bus(0, ebc_pkg::WIN0_CTRL_ADDR, 16'h0, 16'h0000);
        bus(0, ebc_pkg::SYS_CTRL_ADDR, 16'h0, 16'h0000);
        bus(1, ebc_pkg::RST_CFG_ADDR, 16'h0000, 16'h0);
        bus(0, ebc_pkg::RST_CFG_ADDR, 16'h0, 16'h00ff);
        bus(0, 16'hf1fe, 16'h0, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            rs = $urandom;
            c = {rs[2:0], 2'(k), 2'(k), k[0], 2'b10, rs[8:3]};
            reset_dut(1'b0, 1'b0, c);
            check({24'h0, pins.seg_oe}, {24'h0, SEG[k]});
            bus(0, ebc_pkg::RST_CFG_ADDR, 16'h0, {8'h0, 3'b111, c[12:8]});
            bus(0, ebc_pkg::WIN0_CTRL_ADDR, 16'h0, {5'h0, 3'b110, c[7:6], 6'h0});
            bus(0, ebc_pkg::SYS_CTRL_ADDR, 16'h0, {15'h0, !c[8]});
            core(1'b0, 24'h000010, 16'h5a5a, 2'b10, 18'h0);
            check({29'h0, 1'(k != 2), k[0], 1'b1}, {29'h0, cs_low, wr_low, bhe_low});
        end
        foreach (WS[i]) begin
            rs = $urandom;
            w = {rs[1:0], 4'b0001, rs[2], 1'b0, 1'b1, rs[13], rs[3], rs[4], WS[i]};
            a = {15'h0, rs[12:5], 1'b0};
            d = rs[31:16];
            bus(1, ebc_pkg::WIN0_CTRL_ADDR, w, 16'h0);
            bus(0, ebc_pkg::WIN0_CTRL_ADDR, 16'h0, w & ebc_pkg::CTRL_WMASK);
            core(1'b0, a, d, 2'b11, 18'h0);
            core(1'b1, a, 16'h0, 2'b11, {WS[i] != 4'hf, 1'b0, d});
        end
        for (int p = 0; p < 2; p++) begin
            ready_lvl <= p[0];
            bus(1, ebc_pkg::WIN0_CTRL_ADDR, {2'b00, p[0], 5'b10100, 4'b1011, 4'hd}, 16'h0);
            core(1'b1, a, 16'h0, 2'b11, {2'b10, d});
            check({31'h0, 1'(stb_cnt >= 7)}, 32'h1);
        end
        bus(1, ebc_pkg::WIN0_CTRL_ADDR, 16'h0000, 16'h0);
        core(1'b1, a, 16'h0, 2'b11, 18'h10000);
        final_report();
    end
endmodule
`default_nettype wire
